// *** logic/sfr_bank1_pkg.sv ***
// sfr_bank1_pkg: offsets, reset values and field masks of the bank 1
// special register map, shared by the register bank and its bench.
// assumes byte-wide registers reached one per 32-bit Avalon word.
package sfr_bank1_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_NONE = 8'h00;
    localparam logic [7:0] IDX_INDIRECT_DATA = 8'h80;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_PC_LOW = 8'h82;
    localparam logic [7:0] IDX_STATUS = 8'h83;
    localparam logic [7:0] IDX_POINTER = 8'h84;
    localparam logic [7:0] IDX_DIR_A = 8'h85;
    localparam logic [7:0] IDX_DIR_B = 8'h86;
    localparam logic [7:0] IDX_DIR_C = 8'h87;
    localparam logic [7:0] IDX_DIR_D = 8'h88;
    localparam logic [7:0] IDX_DIR_E = 8'h89;
    localparam logic [7:0] IDX_PC_LATCH = 8'h8A;
    localparam logic [7:0] IDX_INT_CTRL = 8'h8B;
    localparam logic [7:0] IDX_IRQ_EN_1 = 8'h8C;
    localparam logic [7:0] IDX_IRQ_EN_2 = 8'h8D;
    localparam logic [7:0] IDX_POWER_FLAGS = 8'h8E;
    localparam logic [7:0] IDX_SERIAL_CTRL_2 = 8'h91;
    localparam logic [7:0] IDX_T2_PERIOD = 8'h92;
    localparam logic [7:0] IDX_SERIAL_ADDR = 8'h93;
    localparam logic [7:0] IDX_SERIAL_STATE = 8'h94;
    localparam logic [7:0] IDX_TX_CTRL = 8'h98;
    localparam logic [7:0] IDX_BAUD_DIV = 8'h99;
    localparam logic [7:0] IDX_VREF_CTRL = 8'h9B;
    localparam logic [7:0] IDX_LVD_CTRL = 8'h9C;
    localparam logic [7:0] IDX_CONV_RES_LOW = 8'h9E;
    localparam logic [7:0] IDX_CONV_CFG_1 = 8'h9F;

    // reset values (all resets agree except for status, pointer, int ctrl bit 0, power flags and converter result)
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [5:0] RST_DIR_A = 6'h3F;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_DIR_E = 8'h07;
    localparam logic [7:0] RST_T2_PERIOD = 8'hFF;
    localparam logic [7:0] RST_TX_CTRL = 8'h02;
    localparam logic [5:0] RST_LVD_CTRL = 6'h05;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h18;
    localparam logic [4:0] RST_PC_LATCH = 5'h00;
    localparam logic [12:0] RST_PC = 13'h0000;
    localparam logic [1:0] RST_POWER_FLAGS = 2'h1; // power-on: flag 0, bo 1

    // status register field positions
    localparam int ST_IRP = 7;
    localparam int ST_TO = 4;
    localparam int ST_PD = 3;

    // writable-bit masks of mixed registers
    localparam logic [7:0] MASK_IRQ_EN_2 = 8'h89;
    localparam logic [7:0] MASK_DIR_E_RW = 8'h17;
    localparam logic [7:0] MASK_TX_CTRL_RW = 8'hF5;
    localparam logic [7:0] MASK_VREF = 8'hF0;
    localparam logic [7:0] MASK_STATUS_RW = 8'hE7;
    localparam logic [5:0] MASK_DIR_A_SMALL = 6'h1F;

endpackage

// *** logic/sfr_bank1.sv ***
// sfr_bank1: bank 1 special register map with program counter latch,
// reset-kind handling and bank mirroring, behind an Avalon-MM slave.
// assumes a single clock; peripheral status arrives as synchronous inputs.
`timescale 1ns/1ns
module sfr_bank1
    import sfr_bank1_pkg::*;
#(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter int ADDR_W = 11
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic brown_out_reset,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic pc_step,
    input wire logic [2:0] int_flag_set,
    input wire logic psp_in_full,
    input wire logic psp_out_full,
    input wire logic psp_overflow,
    input wire logic [5:0] serial_state,
    input wire logic tx_shift_empty,
    input wire logic band_gap_stable,
    input wire logic [7:0] conv_result_low,
    output logic [12:0] program_counter,
    output logic [7:0] option_config,
    output logic [7:0] core_status_flags,
    output logic [7:0] interrupt_control,
    output logic [5:0] port_a_direction,
    output logic [7:0] port_b_direction,
    output logic [7:0] port_c_direction,
    output logic [7:0] port_d_direction,
    output logic [7:0] port_e_direction_psp_status,
    output logic [7:0] timer2_period
);

    // map a bank-qualified index onto its bank 1 register, or none
    function automatic logic [7:0] reg_sel(input logic [8:0] idx);
        logic [7:0] off;
        off = {1'b1, idx[6:0]};
        reg_sel = IDX_NONE;
        case (off)
            IDX_INDIRECT_DATA, IDX_PC_LOW, IDX_STATUS, IDX_POINTER,
            IDX_PC_LATCH, IDX_INT_CTRL: begin
                reg_sel = off;
            end
            IDX_OPTION, IDX_DIR_A, IDX_DIR_B, IDX_DIR_C, IDX_IRQ_EN_1,
            IDX_IRQ_EN_2, IDX_POWER_FLAGS, IDX_SERIAL_CTRL_2, IDX_T2_PERIOD,
            IDX_SERIAL_ADDR, IDX_SERIAL_STATE, IDX_TX_CTRL, IDX_BAUD_DIV,
            IDX_VREF_CTRL, IDX_LVD_CTRL, IDX_CONV_RES_LOW,
            IDX_CONV_CFG_1: begin
                if (idx[8:7] == 2'b01) begin
                    reg_sel = off;
                end
            end
            IDX_DIR_D, IDX_DIR_E: begin
                if (idx[8:7] == 2'b01 && !SMALL_PACKAGE) begin
                    reg_sel = off;
                end
            end
            default: begin
                reg_sel = IDX_NONE;
            end
        endcase
    endfunction

    logic wait_q, wr_fire, other_rst;
    logic [31:0] rdata_q;
    logic [12:0] pc_q;
    logic [4:0] latch_q;
    logic [5:0] dir_a_q, lvd_q;
    logic [1:0] power_q, ser_cfg_q;
    logic [7:0] option_q, status_q, pointer_q, dir_b_q, dir_c_q, dir_d_q;
    logic [7:0] dir_e_q, int_ctrl_q, irq_en_1_q, irq_en_2_q, ser_ctrl_2_q;
    logic [7:0] t2_period_q, ser_addr_q, tx_ctrl_q, baud_q, vref_q;
    logic [7:0] conv_res_q, conv_cfg_q, direct_sel, eff_sel, wdata, rd_val;
    localparam logic [5:0] DIR_A_INIT = SMALL_PACKAGE ?
        (RST_DIR_A & MASK_DIR_A_SMALL) : RST_DIR_A;

    // reset causes: brown-out acts like power-on, pin and watchdog are other
    assign other_rst = !external_reset_pin_n | watchdog_reset;
    assign wdata = avs_writedata[7:0];
    assign wr_fire = avs_write & !wait_q & avs_byteenable[0];

    // indirect port redirects through the pointer; a loop back reads zero
    assign direct_sel = reg_sel(avs_address[ADDR_W-1:2]);
    always_comb begin
        eff_sel = direct_sel;
        if (direct_sel == IDX_INDIRECT_DATA) begin
            eff_sel = reg_sel({status_q[ST_IRP], pointer_q});
            if (eff_sel == IDX_INDIRECT_DATA) begin
                eff_sel = IDX_NONE;
            end
        end
    end

    // read multiplexer; absent bits and locations return zero
    always_comb begin
        rd_val = 8'h00;
        case (eff_sel)
            IDX_OPTION: rd_val = option_q;
            IDX_PC_LOW: rd_val = pc_q[7:0];
            IDX_STATUS: rd_val = status_q;
            IDX_POINTER: rd_val = pointer_q;
            IDX_DIR_A: rd_val = {2'b00, dir_a_q};
            IDX_DIR_B: rd_val = dir_b_q;
            IDX_DIR_C: rd_val = dir_c_q;
            IDX_DIR_D: rd_val = dir_d_q;
            IDX_DIR_E: rd_val = dir_e_q;
            IDX_PC_LATCH: rd_val = {3'b000, latch_q};
            IDX_INT_CTRL: rd_val = int_ctrl_q;
            IDX_IRQ_EN_1: rd_val = irq_en_1_q;
            IDX_IRQ_EN_2: rd_val = irq_en_2_q & MASK_IRQ_EN_2;
            IDX_POWER_FLAGS: rd_val = {6'b000000, power_q};
            IDX_SERIAL_CTRL_2: rd_val = ser_ctrl_2_q;
            IDX_T2_PERIOD: rd_val = t2_period_q;
            IDX_SERIAL_ADDR: rd_val = ser_addr_q;
            IDX_SERIAL_STATE: rd_val = {ser_cfg_q, serial_state};
            IDX_TX_CTRL: rd_val = tx_ctrl_q;
            IDX_BAUD_DIV: rd_val = baud_q;
            IDX_VREF_CTRL: rd_val = vref_q & MASK_VREF;
            IDX_LVD_CTRL: rd_val = {2'b00, lvd_q};
            IDX_CONV_RES_LOW: rd_val = conv_res_q;
            IDX_CONV_CFG_1: rd_val = conv_cfg_q;
            default: rd_val = 8'h00;
        endcase
    end

    // bus slave: one wait cycle, then answer with read data registered
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else if ((avs_read | avs_write) && wait_q) begin
            wait_q <= 1'b0;
            rdata_q <= {24'h000000, rd_val};
        end else begin
            wait_q <= 1'b1;
        end
    end

    // program counter: upper bits come only from the latch on a load
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= RST_PC;
        end else if (brown_out_reset || other_rst) begin
            pc_q <= RST_PC;
        end else if (wr_fire && eff_sel == IDX_PC_LOW) begin
            pc_q <= {latch_q, wdata};
        end else if (pc_step) begin
            pc_q <= pc_q + 13'h0001;
        end
    end

    // program counter latch, cleared by every reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= RST_PC_LATCH;
        end else if (brown_out_reset || other_rst) begin
            latch_q <= RST_PC_LATCH;
        end else if (wr_fire && eff_sel == IDX_PC_LATCH) begin
            latch_q <= wdata[4:0];
        end
    end

    // status: bank bits clear, timeout and power-down follow the cause
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= RST_STATUS;
        end else if (brown_out_reset) begin
            status_q <= RST_STATUS;
        end else if (other_rst) begin
            status_q[7:5] <= 3'b000;
            status_q[ST_TO] <= !watchdog_reset;
            status_q[ST_PD] <= 1'b1;
        end else if (wr_fire && eff_sel == IDX_STATUS) begin
            status_q <= (wdata & MASK_STATUS_RW)
                | (status_q & ~MASK_STATUS_RW);
        end
    end

    // pointer: unchanged across pin and watchdog resets
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pointer_q <= RST_ZERO;
        end else if (brown_out_reset) begin
            pointer_q <= RST_ZERO;
        end else if (!other_rst && wr_fire && eff_sel == IDX_POINTER) begin
            pointer_q <= wdata;
        end
    end

    // port direction registers, all inputs after any reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_a_q <= DIR_A_INIT;
            dir_b_q <= RST_DIR;
            dir_c_q <= RST_DIR;
            dir_d_q <= RST_DIR;
        end else if (brown_out_reset || other_rst) begin
            dir_a_q <= DIR_A_INIT;
            dir_b_q <= RST_DIR;
            dir_c_q <= RST_DIR;
            dir_d_q <= RST_DIR;
        end else if (wr_fire) begin
            if (eff_sel == IDX_DIR_A) begin
                dir_a_q <= SMALL_PACKAGE ? (wdata[5:0] & MASK_DIR_A_SMALL)
                    : wdata[5:0];
            end
            if (eff_sel == IDX_DIR_B) begin
                dir_b_q <= wdata;
            end
            if (eff_sel == IDX_DIR_C) begin
                dir_c_q <= wdata;
            end
            if (eff_sel == IDX_DIR_D) begin
                dir_d_q <= wdata;
            end
        end
    end

    // port e direction and parallel port status; overflow set beats clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_e_q <= RST_DIR_E;
        end else if (brown_out_reset || other_rst) begin
            dir_e_q <= RST_DIR_E;
        end else begin
            dir_e_q[7] <= psp_in_full & !SMALL_PACKAGE;
            dir_e_q[6] <= psp_out_full & !SMALL_PACKAGE;
            if (wr_fire && eff_sel == IDX_DIR_E) begin
                dir_e_q[4:0] <= wdata[4:0] & MASK_DIR_E_RW[4:0];
                dir_e_q[5] <= (wdata[5] & dir_e_q[5])
                    | (psp_overflow & !SMALL_PACKAGE);
            end else if (psp_overflow && !SMALL_PACKAGE) begin
                dir_e_q[5] <= 1'b1;
            end
        end
    end

    // interrupt control; hardware flag set wins over a software write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_ctrl_q <= RST_ZERO;
        end else if (brown_out_reset) begin
            int_ctrl_q <= RST_ZERO;
        end else if (other_rst) begin
            int_ctrl_q[7:1] <= 7'h00;
        end else if (wr_fire && eff_sel == IDX_INT_CTRL) begin
            int_ctrl_q <= wdata | {5'h00, int_flag_set};
        end else begin
            int_ctrl_q[2:0] <= int_ctrl_q[2:0] | int_flag_set;
        end
    end

    // plain read/write configuration registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            option_q <= RST_OPTION;
            irq_en_1_q <= RST_ZERO;
            irq_en_2_q <= RST_ZERO;
            ser_ctrl_2_q <= RST_ZERO;
            t2_period_q <= RST_T2_PERIOD;
            ser_addr_q <= RST_ZERO;
            ser_cfg_q <= 2'b00;
            baud_q <= RST_ZERO;
            vref_q <= RST_ZERO;
            conv_cfg_q <= RST_ZERO;
        end else if (brown_out_reset || other_rst) begin
            option_q <= RST_OPTION;
            irq_en_1_q <= RST_ZERO;
            irq_en_2_q <= RST_ZERO;
            ser_ctrl_2_q <= RST_ZERO;
            t2_period_q <= RST_T2_PERIOD;
            ser_addr_q <= RST_ZERO;
            ser_cfg_q <= 2'b00;
            baud_q <= RST_ZERO;
            vref_q <= RST_ZERO;
            conv_cfg_q <= RST_ZERO;
        end else if (wr_fire) begin
            case (eff_sel)
                IDX_OPTION: option_q <= wdata;
                IDX_IRQ_EN_1: irq_en_1_q <= wdata;
                IDX_IRQ_EN_2: irq_en_2_q <= wdata & MASK_IRQ_EN_2;
                IDX_SERIAL_CTRL_2: ser_ctrl_2_q <= wdata;
                IDX_T2_PERIOD: t2_period_q <= wdata;
                IDX_SERIAL_ADDR: ser_addr_q <= wdata;
                IDX_SERIAL_STATE: ser_cfg_q <= wdata[7:6];
                IDX_BAUD_DIV: baud_q <= wdata;
                IDX_VREF_CTRL: vref_q <= wdata & MASK_VREF;
                IDX_CONV_CFG_1: conv_cfg_q <= wdata;
                default: option_q <= option_q;
            endcase
        end
    end

    // transmit control: shift-empty flag tracks the transmitter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ctrl_q <= RST_TX_CTRL;
        end else if (brown_out_reset || other_rst) begin
            tx_ctrl_q <= RST_TX_CTRL;
        end else begin
            tx_ctrl_q[1] <= tx_shift_empty;
            if (wr_fire && eff_sel == IDX_TX_CTRL) begin
                tx_ctrl_q[7:4] <= wdata[7:4];
                tx_ctrl_q[2] <= wdata[2];
                tx_ctrl_q[0] <= wdata[0];
            end
        end
    end

    // low-voltage detect: band-gap stable bit follows its input
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvd_q <= RST_LVD_CTRL;
        end else if (brown_out_reset || other_rst) begin
            lvd_q <= RST_LVD_CTRL;
        end else begin
            lvd_q[5] <= band_gap_stable;
            if (wr_fire && eff_sel == IDX_LVD_CTRL) begin
                lvd_q[4:0] <= wdata[4:0];
            end
        end
    end

    // power flags: power-on clears one, brown-out the other
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_q <= RST_POWER_FLAGS;
        end else if (brown_out_reset) begin
            power_q[0] <= 1'b0;
        end else if (!other_rst && wr_fire && eff_sel == IDX_POWER_FLAGS) begin
            power_q <= wdata[1:0];
        end
    end

    // converter result captured each cycle; keeps value during brown-out, pin and watchdog resets, cleared by rst_n
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_res_q <= RST_ZERO;
        end else if (!brown_out_reset && !other_rst) begin
            conv_res_q <= conv_result_low;
        end
    end

    // outputs straight from the registers
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign program_counter = pc_q;
    assign option_config = option_q;
    assign core_status_flags = status_q;
    assign interrupt_control = int_ctrl_q;
    assign port_a_direction = dir_a_q;
    assign port_b_direction = dir_b_q;
    assign port_c_direction = dir_c_q;
    assign port_d_direction = dir_d_q;
    assign port_e_direction_psp_status = dir_e_q;
    assign timer2_period = t2_period_q;

endmodule

// *** sim/sfr_bank1_chk.sv ***
// sfr_bank1_chk: bus answer and reset-value assertions for the bank.
// assumes it is bound to sfr_bank1 and sees only that module's ports.
`timescale 1ns/1ns
module sfr_bank1_chk #(
    parameter bit SMALL_PACKAGE = 1'b0,
    parameter int ADDR_W = 11
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic brown_out_reset,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic pc_step,
    input wire logic [2:0] int_flag_set,
    input wire logic [12:0] program_counter,
    input wire logic [7:0] option_config,
    input wire logic [7:0] core_status_flags,
    input wire logic [7:0] interrupt_control,
    input wire logic [5:0] port_a_direction,
    input wire logic [7:0] timer2_period
);
    // decoded request conditions; indirect writes may also move the pc
    logic [8:0] idx;
    logic srst, take_rd, pcl_direct, pcl_any;
    assign idx = avs_address[10:2];
    assign srst = brown_out_reset | !external_reset_pin_n | watchdog_reset;
    assign take_rd = avs_read & avs_waitrequest;
    assign pcl_direct = avs_write & !avs_waitrequest & avs_byteenable[0]
        & (idx[6:0] == 7'h02);
    assign pcl_any = pcl_direct | (avs_write & (idx[6:0] == 7'h00));

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    upper_zero_a: assert property (!avs_waitrequest |->
        avs_readdata[31:8] == 24'h000000) else $error("upper bytes set");
    unimpl_read_a: assert property (take_rd && (idx == 9'h08F ||
        idx == 9'h090 || idx == 9'h09D) |=> avs_readdata == 32'h0)
        else $error("unimplemented read not zero");
    small_absent_a: assert property (take_rd && SMALL_PACKAGE &&
        (idx == 9'h088 || idx == 9'h089) |=> avs_readdata == 32'h0)
        else $error("absent register not zero");
    small_bit_a: assert property (SMALL_PACKAGE |->
        !port_a_direction[5]) else $error("absent direction bit set");
    pc_upper_hold_a: assert property (!$past(pc_step) &&
        !$past(srst) && !$past(pcl_any) |->
        $stable(program_counter[12:8])) else $error("pc upper moved");
    pc_load_a: assert property (pcl_direct && !srst && !pc_step |=>
        program_counter[7:0] == $past(avs_writedata[7:0]))
        else $error("pc low not loaded");
    brown_out_a: assert property (brown_out_reset &&
        int_flag_set == 3'h0 |=> option_config == 8'hFF &&
        timer2_period == 8'hFF && program_counter == 13'h0000 &&
        core_status_flags == 8'h18 && interrupt_control == 8'h00)
        else $error("brown-out values wrong");
    wdt_status_a: assert property (watchdog_reset &&
        !brown_out_reset |=> core_status_flags[4:3] == 2'b01 &&
        option_config == 8'hFF) else $error("watchdog values wrong");
    pin_status_a: assert property (!external_reset_pin_n &&
        !watchdog_reset && !brown_out_reset |=>
        core_status_flags[4:3] == 2'b11 && timer2_period == 8'hFF)
        else $error("pin reset values wrong");
    kept_bits_a: assert property ((watchdog_reset ||
        !external_reset_pin_n) && !brown_out_reset && !int_flag_set[0] |=>
        core_status_flags[2:0] == $past(core_status_flags[2:0]) &&
        interrupt_control[0] == $past(interrupt_control[0]) &&
        core_status_flags[7:5] == 3'b000) else $error("kept bits lost");
endmodule

bind sfr_bank1 sfr_bank1_chk #(.SMALL_PACKAGE(SMALL_PACKAGE),
    .ADDR_W(ADDR_W)) chk_u (.*);

// *** sim/sfr_bank1_tb_top.sv ***
// sfr_bank1_tb_top: register table walk, mirrors, pc latch, resets.
// assumes the small-package bank and a 250 MHz clock.
`timescale 1ns/1ns
module sfr_bank1_tb_top import sfr_bank1_pkg::*;;
    logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [10:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic brown_out_reset, external_reset_pin_n, watchdog_reset, pc_step;
    logic [2:0] int_flag_set;
    logic psp_in_full, psp_out_full, psp_overflow, tx_shift_empty;
    logic band_gap_stable;
    logic [5:0] serial_state, port_a_direction;
    logic [7:0] conv_result_low, option_config, core_status_flags;
    logic [7:0] interrupt_control, port_b_direction, port_c_direction;
    logic [7:0] port_d_direction, port_e_direction_psp_status;
    logic [7:0] timer2_period;
    logic [12:0] program_counter;
    int mismatches, n_compared;
    // rows: index, reset read, write data, read after write
    logic [31:0] rows [28] = '{32'h81FF1212, 32'h82004444, 32'h83180018,
        32'h8400A5A5, 32'h851FFF1F, 32'h86FF5A5A, 32'h87FF3C3C,
        32'h88005A00, 32'h89005A00, 32'h8A00FF1F, 32'h8B00F8F8,
        32'h8C007F7F, 32'h8D00FF89, 32'h8F00FF00, 32'h9000FF00,
        32'h91000000, 32'h92FF1212, 32'h93003434, 32'h942AC0EA,
        32'h9500FF00, 32'h9802FFF7, 32'h99007777, 32'h9A00FF00,
        32'h9B00FFF0, 32'h9C050A0A, 32'h9D00FF00, 32'h9E960096,
        32'h9F00C3C3};

    sfr_bank1 #(.SMALL_PACKAGE(1'b1)) dut_u (.*);

    // free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one write, held until waitrequest is seen low
    task automatic wr(input logic [8:0] idx, input logic [7:0] d);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    // one read, data taken at the edge that sees waitrequest low
    task automatic rd_chk(input logic [8:0] idx, input logic [7:0] exp);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        chk($sformatf("reg %h", idx), {24'h000000, exp}, avs_readdata);
        @(posedge ref_clk);
    endtask

    // one-cycle pulse: flag0, brown-out, watchdog, pin, pc step
    task automatic kick(input logic [4:0] v);
        {int_flag_set[0], brown_out_reset, watchdog_reset,
            external_reset_pin_n, pc_step} <= v ^ 5'h02;
        @(posedge ref_clk);
        {int_flag_set[0], brown_out_reset, watchdog_reset,
            external_reset_pin_n, pc_step} <= 5'h02;
        @(posedge ref_clk);
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        end_sim();
    end

    // main sequence
    initial begin
        mismatches = 0;
        n_compared = 0;
        rst_n = 1'b0;
        {avs_read, avs_write, brown_out_reset, watchdog_reset, pc_step,
            psp_in_full, psp_out_full, psp_overflow, band_gap_stable} = '0;
        {int_flag_set, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        external_reset_pin_n = 1'b1;
        tx_shift_empty = 1'b1;
        serial_state = 6'h2A;
        conv_result_low = 8'h96;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chk("option", {24'h0, RST_OPTION}, {24'h0, option_config});
        chk("period", {24'h0, RST_T2_PERIOD}, {24'h0, timer2_period});
        chk("dir b", 32'h000000FF, {24'h0, port_b_direction});
        chk("dir a", 32'h0000001F, {26'h0, port_a_direction});
        foreach (rows[i]) begin
            rd_chk({1'b0, rows[i][31:24]}, rows[i][23:16]);
            wr({1'b0, rows[i][31:24]}, rows[i][15:8]);
            rd_chk({1'b0, rows[i][31:24]}, rows[i][7:0]);
        end
        chk("pc", 32'h00000044, {19'h0, program_counter});
        chk("dir d", 32'hFF, {24'h0, port_d_direction});
        for (int b = 0; b < 4; b++) begin
            rd_chk({b[1:0], 7'h0A}, 8'h1F);
            rd_chk({b[1:0], 7'h04}, 8'hA5);
        end
        rd_chk(9'h186, 8'h00);
        wr(9'h10B, 8'h30);
        rd_chk(9'h08B, 8'h30);
        wr(9'h182, 8'h20);
        chk("pc", 32'h00001F20, {19'h0, program_counter});
        wr(9'h08A, 8'h03);
        kick(5'h01);
        chk("pc", 32'h00001F21, {19'h0, program_counter});
        wr(9'h002, 8'h00);
        chk("pc", 32'h00000300, {19'h0, program_counter});
        // indirect access through the pointer from other banks
        wr(9'h084, 8'h92);
        rd_chk(9'h100, 8'h12);
        wr(9'h180, 8'h55);
        chk("period", 32'h00000055, {24'h0, timer2_period});
        wr(9'h084, 8'h80);
        rd_chk(9'h080, 8'h00);
        // parallel port status bits are absent on the small package
        {band_gap_stable, psp_in_full, psp_out_full, psp_overflow} <= 4'hF;
        tx_shift_empty <= 1'b0;
        conv_result_low <= 8'h3C;
        @(posedge ref_clk);
        rd_chk(9'h09C, 8'h2A);
        rd_chk(9'h098, 8'hF5);
        rd_chk(9'h09E, 8'h3C);
        chk("dir e", 32'h7, {24'h0, port_e_direction_psp_status});
        // reset kinds: watchdog, pin, brown-out
        kick(5'h10);
        rd_chk(9'h08B, 8'h31);
        kick(5'h04);
        rd_chk(9'h083, 8'h08);
        rd_chk(9'h08B, 8'h01);
        rd_chk(9'h084, 8'h80);
        rd_chk(9'h08E, 8'h01);
        chk("option", 32'h000000FF, {24'h0, option_config});
        chk("dir c", 32'hFF, {24'h0, port_c_direction});
        kick(5'h02);
        rd_chk(9'h083, 8'h18);
        kick(5'h08);
        rd_chk(9'h08E, 8'h00);
        rd_chk(9'h08B, 8'h00);
        chk("pc", 32'h00000000, {19'h0, program_counter});
        end_sim();
    end
endmodule
